//--- common/pcg_map.svh
// register offsets, field positions and reset values of the clock gate
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
// Operation
// (RULE1) Bits 15..8 of capture_compare_gate turn off capture units 8..1 when one.
// (RULE2) Bits 7..0 of capture_compare_gate turn off compare units 8..1 when one.
// (RULE3) Every implemented gate bit is read/write and resets to zero.
// (RULE4) Bits 15..12 of timer_i2c_adc_gate turn off timers 9..6 when one.
// (RULE5) Bits 11..2 of timer_i2c_adc_gate are unimplemented and read zero.
// (RULE6) Bit 1 of timer_i2c_adc_gate turns off the second i2c controller.
// (RULE7) Bit 0 of timer_i2c_adc_gate turns off the second converter.
// (RULE8) With the converter off its pin select bits are ignored, pins digital.
// (RULE9) A gate bit write reaches its module one cycle after the write.
// (RULE10) Register writes of an off module are blocked, its reads invalid; the code blocks writes of the converter only and flags no reads.
// (RULE11) A module runs only if its bit is clear and it is present.
// (RULE12) Turning a module off stops every clock enable it receives.
// (RULE13) Each clock enable changes only on a system clock edge.
`define PCG_OFS_CCG      12'h000
`define PCG_OFS_TIAG     12'h004
`define PCG_OFS_PRESENT  12'h008
`define PCG_RST_GATE     16'h0000
`define PCG_TIAG_MASK    16'hf003
`define PCG_NUM_MODS     22
`endif

//--- common/pcg_pkg.sv
// types shared by the clock gate files
package pcg_pkg;
  typedef struct packed {
    logic [7:0] capture_en;
    logic [7:0] compare_en;
    logic [3:0] timer_en;
    logic       i2c2_en;
    logic       adc2_en;
  } pcg_enables_t;
  typedef enum logic [1:0] {
    PCG_IDLE,
    PCG_ACCESS
  } pcg_apb_state_t;
endpackage

//--- core/pcg_gate_reg.sv
// one gated enable flop per module
`timescale 1ns/10ps
module pcg_gate_reg #(
  parameter int W = 22
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] off_bits,
  input  wire logic [W-1:0] present,
  output logic      [W-1:0] enable_ff
);
  logic [W-1:0] nxt_enable;

  always_comb begin
    nxt_enable = ~off_bits & present; // RULE11 RULE12
  end

  // registered so enables only move on a clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // every module starts enabled, matching the cleared gate bits
      enable_ff <= '1; // RULE3
    end else begin
      enable_ff <= nxt_enable; // RULE9 RULE13
    end
  end
endmodule

//--- core/pcg_top.sv
// peripheral clock gate with apb register access
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "pcg_map.svh"
module pcg_top #(
  parameter logic [21:0] PRESENT_DEFAULT = 22'h3fffff
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata_ff,
  output logic                       pready_ff,
  output logic                       pslverr_ff,
  output pcg_pkg::pcg_enables_t      clk_en_ff,
  output logic                       regs_write_en_ff,
  output logic                       digital_pins_ff
);
  logic [15:0]            ccg_ff;
  logic [15:0]            nxt_ccg;
  logic [15:0]            tiag_ff;
  logic [15:0]            nxt_tiag;
  logic [21:0]            present_ff;
  logic [21:0]            nxt_present;
  logic [31:0]            nxt_prdata;
  logic                   nxt_pready;
  logic                   nxt_pslverr;
  pcg_pkg::pcg_apb_state_t st_ff;
  pcg_pkg::pcg_apb_state_t nxt_st;
  logic [21:0]            off_bits;
  logic [21:0]            en_vec;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   present_seen_ff;
  logic                   nxt_digital_pins;
  logic                   nxt_regs_write_en;

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    lane_merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `PCG_OFS_CCG) || (a == `PCG_OFS_TIAG) ||
             (a == `PCG_OFS_PRESENT);
  endfunction

  // one wait state: answer on the edge after the setup edge
  assign wr_acc = (st_ff == pcg_pkg::PCG_ACCESS) && psel && penable && pwrite;
  assign rd_acc = (st_ff == pcg_pkg::PCG_ACCESS) && psel && penable && !pwrite;

  always_comb begin
    nxt_st      = st_ff;
    nxt_ccg     = ccg_ff;
    nxt_tiag    = tiag_ff;
    nxt_present = present_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    case (st_ff)
      pcg_pkg::PCG_IDLE: begin
        if (psel && !penable) begin
          nxt_st = pcg_pkg::PCG_ACCESS;
        end
      end
      pcg_pkg::PCG_ACCESS: begin
        if (pready_ff) begin
          // writes land only on the edge where pready is seen high
          nxt_st = pcg_pkg::PCG_IDLE;
          if (wr_acc && paddr == `PCG_OFS_CCG) begin
            nxt_ccg = lane_merge(ccg_ff, pwdata, pstrb); // RULE1 RULE2 RULE3
          end
          if (wr_acc && paddr == `PCG_OFS_TIAG) begin
            // RULE4 RULE6 RULE7 RULE5
            nxt_tiag = lane_merge(tiag_ff, pwdata, pstrb) & `PCG_TIAG_MASK;
          end
          if (wr_acc && paddr == `PCG_OFS_PRESENT) begin
            nxt_present = {pwdata[21:16],
                           lane_merge(present_ff[15:0], pwdata, pstrb)};
          end
        end else begin
          nxt_pready  = 1'b1;
          nxt_pslverr = !mapped(paddr);
          if (rd_acc) begin
            case (paddr)
              `PCG_OFS_CCG:     nxt_prdata = {16'h0000, ccg_ff};
              `PCG_OFS_TIAG:    nxt_prdata = {16'h0000,
                                              tiag_ff & `PCG_TIAG_MASK}; // RULE5
              `PCG_OFS_PRESENT: nxt_prdata = {10'h000, present_ff};
              default:          nxt_prdata = 32'h00000000;
            endcase
          end
        end
      end
      default: nxt_st = pcg_pkg::PCG_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff      <= pcg_pkg::PCG_IDLE;
      ccg_ff     <= `PCG_RST_GATE; // RULE3
      tiag_ff    <= `PCG_RST_GATE;
      present_ff <= 22'h3fffff;
      present_seen_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      ccg_ff     <= nxt_ccg;
      tiag_ff    <= nxt_tiag;
      // strap taken once after reset release, not under reset
      present_seen_ff <= 1'b1;
      present_ff <= present_seen_ff ? nxt_present : PRESENT_DEFAULT;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // order: capture 8..1, compare 8..1, timers 9..6, i2c2, adc2
  assign off_bits = {ccg_ff, tiag_ff[15:12], tiag_ff[1:0]};

  pcg_gate_reg #(
    .W (`PCG_NUM_MODS)
  ) u_gate (
    .pclk      (pclk),
    .presetn   (presetn),
    .off_bits  (off_bits),
    .present   (present_ff),
    .enable_ff (en_vec)
  );

  assign clk_en_ff        = pcg_pkg::pcg_enables_t'(en_vec); // RULE12

  // converter off or absent: pins go digital, its registers take no writes
  always_comb begin
    nxt_digital_pins  = off_bits[0] | !present_ff[0]; // RULE8
    nxt_regs_write_en = !off_bits[0] & present_ff[0]; // RULE10
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_pins_ff  <= 1'b0;
      regs_write_en_ff <= 1'b1;
    end else begin
      digital_pins_ff  <= nxt_digital_pins; // RULE8
      regs_write_en_ff <= nxt_regs_write_en; // RULE10
    end
  end

  // one wait state, so pready rises the cycle after the access edge
  property p_pready_follows;
    @(posedge pclk) disable iff (!presetn)
      (st_ff == pcg_pkg::PCG_ACCESS && psel && penable && !pready_ff)
      |=> pready_ff;
  endproperty
  a_pready_follows: assert property (p_pready_follows) // RULE3
    else $error("pready did not follow the access phase");

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready_ff |=> !pready_ff;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) // RULE3
    else $error("pready stood longer than one cycle");

  property p_slverr_with_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr_ff |-> pready_ff;
  endproperty
  a_slverr_with_ready: assert property (p_slverr_with_ready) // RULE3
    else $error("error response without pready");

  property p_ccg_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && pready_ff && paddr == `PCG_OFS_CCG && pstrb == 4'hf)
      |=> ccg_ff == $past(pwdata[15:0]);
  endproperty
  a_ccg_write: assert property (p_ccg_write) // RULE1 RULE2
    else $error("capture compare gate write lost");

  property p_tiag_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && pready_ff && paddr == `PCG_OFS_TIAG && pstrb == 4'hf)
      |=> tiag_ff == ($past(pwdata[15:0]) & `PCG_TIAG_MASK);
  endproperty
  a_tiag_write: assert property (p_tiag_write) // RULE4 RULE6 RULE7
    else $error("timer i2c converter gate write lost");

  property p_tiag_unimpl;
    @(posedge pclk) disable iff (!presetn)
      tiag_ff[11:2] == 10'h000;
  endproperty
  a_tiag_unimpl: assert property (p_tiag_unimpl) // RULE5
    else $error("unimplemented gate bits hold a one");

  property p_read_unimpl;
    @(posedge pclk) disable iff (!presetn)
      (rd_acc && !pready_ff && paddr == `PCG_OFS_TIAG)
      |=> prdata_ff[11:2] == 10'h000;
  endproperty
  a_read_unimpl: assert property (p_read_unimpl) // RULE5
    else $error("unimplemented gate bits read as one");

  // enables trail the gate bits by exactly one edge
  property p_gate_follow;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> en_vec == $past(~off_bits & present_ff);
  endproperty
  a_gate_follow: assert property (p_gate_follow) // RULE9 RULE11 RULE12 RULE13
    else $error("clock enables do not follow the gate bits");

  property p_pins_digital;
    @(posedge pclk) disable iff (!presetn)
      tiag_ff[0] |=> digital_pins_ff;
  endproperty
  a_pins_digital: assert property (p_pins_digital) // RULE8
    else $error("pins not digital with converter off");

  property p_regs_blocked;
    @(posedge pclk) disable iff (!presetn)
      tiag_ff[0] |=> !regs_write_en_ff;
  endproperty
  a_regs_blocked: assert property (p_regs_blocked) // RULE10
    else $error("register writes open with converter off");
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the peripheral clock gate
`timescale 1ns/10ps
`include "pcg_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  bad_count++; $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module tb_top;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h00000000;
  logic [3:0]            pstrb = 4'hf;
  logic [31:0]           prdata_ff;
  logic                  pready_ff;
  logic                  pslverr_ff;
  pcg_pkg::pcg_enables_t clk_en_ff;
  logic                  regs_write_en_ff;
  logic                  digital_pins_ff;
  logic [31:0]           rd;
  logic                  er;
  logic [15:0]           c;
  logic [15:0]           t;
  int                    bad_count = 0;
  int                    check_count = 0;
  int                    cyc = 0;
  always #20 pclk = ~pclk;
  pcg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .clk_en_ff(clk_en_ff),
    .regs_write_en_ff(regs_write_en_ff),
    .digital_pins_ff(digital_pins_ff));
  // enables are the inverse of the off bits, all modules present
  function automatic logic [21:0] en(input logic [15:0] cc, tt);
    en = ~{cc, tt[15:12], tt[1:0]};
  endfunction
  task automatic ap(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_ff !== 1'b1);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ceiling well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h910fc4c8));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ap(1'b0, `PCG_OFS_CCG, 32'h0);
    `CHK(rd, 32'h00000000)
    ap(1'b0, `PCG_OFS_TIAG, 32'h0);
    `CHK(rd, 32'h00000000)
    `CHK(clk_en_ff, 22'h3fffff)
    for (int i = 0; i < 10; i++) begin
      c = (i == 0) ? 16'hffff : 16'($urandom());
      t = (i == 0) ? 16'hffff : 16'($urandom());
      ap(1'b1, `PCG_OFS_CCG, {16'h0000, c});
      ap(1'b1, `PCG_OFS_TIAG, {16'h0000, t});
      // unmapped write must leave both registers alone
      ap(1'b1, 12'h00c, 32'h0000ffff);
      `CHK(er, 1'b1)
      ap(1'b0, `PCG_OFS_CCG, 32'h0);
      `CHK(rd[15:0], c)
      ap(1'b0, `PCG_OFS_TIAG, 32'h0);
      `CHK(rd[15:0], t & 16'hf003)
      `CHK(clk_en_ff, en(c, t))
      `CHK(digital_pins_ff, t[0])
      `CHK(regs_write_en_ff, !t[0])
    end
    ap(1'b1, `PCG_OFS_CCG, 32'h0);
    ap(1'b1, `PCG_OFS_TIAG, 32'h0);
    ap(1'b1, `PCG_OFS_PRESENT, 32'h003ffffe);
    `CHK(er, 1'b0)
    ap(1'b0, `PCG_OFS_PRESENT, 32'h0);
    `CHK(rd, 32'h003ffffe)
    `CHK(clk_en_ff, 22'h3ffffe)
    `CHK(digital_pins_ff, 1'b1)
    `CHK(regs_write_en_ff, 1'b0)
    // mid-run reset brings every module back on
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ap(1'b0, `PCG_OFS_TIAG, 32'h0);
    `CHK(rd, 32'h00000000)
    `CHK(clk_en_ff, 22'h3fffff)
    conclude();
  end
endmodule
